// ==== logic/gpk_regs.vh ====
// register offsets, field positions and reset values for the port block
`ifndef GPK_REGS_VH
`define GPK_REGS_VH
`define GPK_PULLUP_ASSIGN_OFS 8'h2c
`define GPK_SYS_OPTIONS_TWO_OFS 8'h38
`define GPK_PORT_H_DATA_OFS 8'h7c
`define GPK_PORT_H_DIR_OFS 8'h7d
`define GPK_PORT_J_DATA_OFS 8'h8e
`define GPK_PORT_J_DIR_OFS 8'h8f
`define GPK_PORT_K_DATA_OFS 8'h9e
`define GPK_PORT_K_DIR_OFS 8'h9f
`define GPK_PULLUP_RESET 8'h0f
`define GPK_PULLUP_MASK 8'h0f
`define GPK_DIR_RESET 8'h00
`define GPK_SYS_OPTIONS_TWO_REG_RESET 8'h00
`define GPK_SYS_OPTIONS_TWO_REG_MASK 8'hdf
`define GPK_B_PULLUP_BIT 0
`define GPK_F_PULLUP_BIT 1
`define GPK_G_PULLUP_BIT 2
`define GPK_H_PULLUP_BIT 3
`define GPK_AUX_DIV_LO 0
`define GPK_AUX_DIV_HI 1
`define GPK_SPI_RATE_BIT 2
`define GPK_SPI_LSB_BIT 3
`define GPK_READ_VIS_BIT 4
`define GPK_OPEN_DRAIN_BIT 6
`define GPK_LOAD_DRIVE_BIT 7
`endif

// ==== logic/gpk_ports.v ====
// ports h, j and k with pull-up assignment and options register 2
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "gpk_regs.vh"

module gpk_ports
(
   input wire clk_sys,
   input wire srst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [7:0] rdata,
   input wire single_chip_mode,
   input wire read_vis_reset_val,
   input wire global_pullup_en,
   input wire aux_clock_out_en,
   input wire e_clock,
   input wire aux_clock,
   input wire [7:0] h_alt_en,
   input wire [7:0] h_alt_out,
   input wire [7:0] j_alt_en,
   input wire [7:0] j_alt_out,
   input wire [7:0] k_alt_en,
   input wire [7:0] k_alt_out,
   input wire [7:0] port_h_in,
   output reg [7:0] port_h_out,
   output reg [7:0] port_h_oe_n,
   output reg [7:0] port_h_pullup,
   input wire [7:0] port_j_in,
   output reg [7:0] port_j_out,
   output reg [7:0] port_j_oe_n,
   input wire [7:0] port_k_in,
   output reg [7:0] port_k_out,
   output reg [7:0] port_k_oe_n,
   output reg [2:0] j_timer_in,
   output reg [2:0] k_timer_in,
   output reg b_pullup_on,
   output reg f_pullup_on,
   output reg g_pullup_on,
   output reg port_c_open_drain,
   output reg int_read_vis,
   output reg e_pin_out,
   output reg spi_lsb_first,
   output reg spi_rate_sel_hi,
   output reg load_instr_drive_en,
   output reg [1:0] aux_clk_div_sel,
   output reg aux_clock_pin
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg [7:0] port_h_data_reg;
   reg [7:0] port_j_data_reg;
   reg [7:0] port_k_data_reg;
   reg [7:0] port_h_dir_reg;
   reg [7:0] port_j_dir_reg;
   reg [7:0] port_k_dir_reg;
   reg [7:0] pullup_assign_reg;
   reg [7:0] sys_options_two_reg;
   reg reset_seen;
   reg [7:0] next_rdata;

   // read mux: input pins show pin level, outputs show the latch
   function [7:0] port_view;
      input [7:0] data;
      input [7:0] dir;
      input [7:0] pins;
      begin
         port_view = (data & dir) | (pins & ~dir);
      end
   endfunction

   // pin driver: alternate function owns the pin when enabled
   function [7:0] pin_drive;
      input [7:0] data;
      input [7:0] alt_en;
      input [7:0] alt_out;
      begin
         pin_drive = (alt_out & alt_en) | (data & ~alt_en);
      end
   endfunction

   // ---------------------------------------------------------------
   // data registers: no reset so contents survive it
   // ---------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (wr_stb && addr == `GPK_PORT_H_DATA_OFS)
         port_h_data_reg <= wdata;
      if (wr_stb && addr == `GPK_PORT_J_DATA_OFS)
         port_j_data_reg <= wdata;
      if (wr_stb && addr == `GPK_PORT_K_DATA_OFS)
         port_k_data_reg <= wdata;
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         port_h_dir_reg <= `GPK_DIR_RESET;
         port_j_dir_reg <= `GPK_DIR_RESET;
         port_k_dir_reg <= `GPK_DIR_RESET;
         pullup_assign_reg <= `GPK_PULLUP_RESET;
         sys_options_two_reg <= `GPK_SYS_OPTIONS_TWO_REG_RESET;
         reset_seen <= 1'b1;
      end
      else
      begin
         reset_seen <= 1'b0;
         // mode-dependent bit caught in the first cycle after release
         if (reset_seen)
            sys_options_two_reg[`GPK_READ_VIS_BIT] <=
               read_vis_reset_val;
         if (wr_stb)
         begin
            if (addr == `GPK_PORT_H_DIR_OFS)
               port_h_dir_reg <= wdata;
            else if (addr == `GPK_PORT_J_DIR_OFS)
               port_j_dir_reg <= wdata;
            else if (addr == `GPK_PORT_K_DIR_OFS)
               port_k_dir_reg <= wdata;
            else if (addr == `GPK_PULLUP_ASSIGN_OFS)
               pullup_assign_reg <= wdata & `GPK_PULLUP_MASK;
            else if (addr == `GPK_SYS_OPTIONS_TWO_OFS)
               sys_options_two_reg <= wdata & `GPK_SYS_OPTIONS_TWO_REG_MASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // register read, data one cycle after the strobe
   // ---------------------------------------------------------------
   always @*
   begin
      next_rdata = 8'h00;
      if (addr == `GPK_PORT_H_DATA_OFS)
         next_rdata = port_view(port_h_data_reg, port_h_dir_reg, port_h_in);
      else if (addr == `GPK_PORT_H_DIR_OFS)
         next_rdata = port_h_dir_reg;
      else if (addr == `GPK_PORT_J_DATA_OFS)
         next_rdata = port_view(port_j_data_reg, port_j_dir_reg, port_j_in);
      else if (addr == `GPK_PORT_J_DIR_OFS)
         next_rdata = port_j_dir_reg;
      else if (addr == `GPK_PORT_K_DATA_OFS)
         next_rdata = port_view(port_k_data_reg, port_k_dir_reg, port_k_in);
      else if (addr == `GPK_PORT_K_DIR_OFS)
         next_rdata = port_k_dir_reg;
      else if (addr == `GPK_PULLUP_ASSIGN_OFS)
         next_rdata = pullup_assign_reg;
      else if (addr == `GPK_SYS_OPTIONS_TWO_OFS)
         next_rdata = sys_options_two_reg;
   end

   always @(posedge clk_sys)
   begin
      if (srst)
         rdata <= 8'h00;
      else if (rd_stb)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   // ---------------------------------------------------------------
   // pins and derived controls
   // ---------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         port_h_out <= 8'h00;
         port_h_oe_n <= 8'hff;
         port_h_pullup <= 8'h00;
         port_j_out <= 8'h00;
         port_j_oe_n <= 8'hff;
         port_k_out <= 8'h00;
         port_k_oe_n <= 8'hff;
         j_timer_in <= 3'h0;
         k_timer_in <= 3'h0;
         b_pullup_on <= 1'b0;
         f_pullup_on <= 1'b0;
         g_pullup_on <= 1'b0;
         port_c_open_drain <= 1'b0;
         int_read_vis <= 1'b0;
         e_pin_out <= 1'b0;
         spi_lsb_first <= 1'b0;
         spi_rate_sel_hi <= 1'b0;
         load_instr_drive_en <= 1'b0;
         aux_clk_div_sel <= 2'h0;
         aux_clock_pin <= 1'b0;
      end
      else
      begin
         port_h_out <= pin_drive(port_h_data_reg, h_alt_en, h_alt_out);
         // alternate function may drive pin even with direction clear
         port_h_oe_n <= ~(port_h_dir_reg | h_alt_en);
         port_j_out <= pin_drive(port_j_data_reg, j_alt_en, j_alt_out);
         port_j_oe_n <= ~(port_j_dir_reg | j_alt_en);
         port_k_out <= pin_drive(port_k_data_reg, k_alt_en, k_alt_out);
         port_k_oe_n <= ~(port_k_dir_reg | k_alt_en);
         // capture 4 on pin 7, external count on pin 3
         j_timer_in <= {port_j_in[7], 1'b0, port_j_in[3]};
         k_timer_in <= {port_k_in[7], 1'b0, port_k_in[3]};
         // port h pull-ups only on pins whose direction bit is clear, even when the alternate function drives them
         port_h_pullup <= {8{global_pullup_en &
            pullup_assign_reg[`GPK_H_PULLUP_BIT]}} &
            ~port_h_dir_reg;
         g_pullup_on <= global_pullup_en &
            pullup_assign_reg[`GPK_G_PULLUP_BIT];
         f_pullup_on <= global_pullup_en & single_chip_mode &
            pullup_assign_reg[`GPK_F_PULLUP_BIT];
         b_pullup_on <= global_pullup_en & single_chip_mode &
            pullup_assign_reg[`GPK_B_PULLUP_BIT];
         port_c_open_drain <=
            sys_options_two_reg[`GPK_OPEN_DRAIN_BIT];
         int_read_vis <= ~single_chip_mode &
            sys_options_two_reg[`GPK_READ_VIS_BIT];
         e_pin_out <= e_clock & ~(single_chip_mode &
            sys_options_two_reg[`GPK_READ_VIS_BIT]);
         spi_lsb_first <= sys_options_two_reg[`GPK_SPI_LSB_BIT];
         spi_rate_sel_hi <= sys_options_two_reg[`GPK_SPI_RATE_BIT];
         load_instr_drive_en <=
            sys_options_two_reg[`GPK_LOAD_DRIVE_BIT];
         aux_clk_div_sel <= sys_options_two_reg[`GPK_AUX_DIV_HI:
            `GPK_AUX_DIV_LO];
         aux_clock_pin <= aux_clock & aux_clock_out_en;
      end
   end

endmodule // gpk_ports

// ==== test/gpk_ports_props.sv ====
// concurrent checks on the port block's outputs
`timescale 1ns/100ps
module gpk_ports_props
(
   input wire clk_sys,
   input wire srst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] rdata,
   input wire single_chip_mode,
   input wire global_pullup_en,
   input wire aux_clock_out_en,
   input wire [7:0] h_alt_en,
   input wire [7:0] port_h_oe_n,
   input wire [7:0] port_h_pullup,
   input wire b_pullup_on,
   input wire f_pullup_on,
   input wire g_pullup_on,
   input wire spi_lsb_first,
   input wire load_instr_drive_en,
   input wire aux_clock_pin
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (srst);
sequence s_dir_wr;
   wr_stb && addr == 8'h7d && h_alt_en == 8'h00;
endsequence
sequence s_opt_wr;
   wr_stb && addr == 8'h38;
endsequence
a_dir_drive: assert property (s_dir_wr ##1 h_alt_en == 8'h00 |=>
   port_h_oe_n == ~$past(wdata, 2)) else $error("dir write not on pins");
a_pu_hi_zero: assert property (rd_stb && addr == 8'h2c |=>
   rdata[7:4] == 4'h0) else $error("pull-up upper bits not zero");
a_opt_bit5: assert property (rd_stb && addr == 8'h38 |=>
   !rdata[5]) else $error("options bit 5 not zero");
a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
   else $error("read data outside read cycle");
a_global_off: assert property (!global_pullup_en ##1 !global_pullup_en
   |-> port_h_pullup == 8'h00 && !b_pullup_on && !f_pullup_on
   && !g_pullup_on) else $error("pull-up on while globally off");
a_exp_fb: assert property (!single_chip_mode ##1 !single_chip_mode
   |-> !f_pullup_on && !b_pullup_on) else $error("f/b pull-up in expanded");
a_aux_off: assert property (!aux_clock_out_en ##1 1'b1 |->
   !aux_clock_pin) else $error("aux clock pin active while disabled");
a_opt_wr: assert property (s_opt_wr |-> ##2
   spi_lsb_first == $past(wdata[3], 2)
   && load_instr_drive_en == $past(wdata[7], 2))
   else $error("options write not on outputs");
a_h_pu_in: assert property ((port_h_pullup & ~port_h_oe_n
   & ~$past(h_alt_en)) == 8'h00) else $error("pull-up on output pin");
endmodule // gpk_ports_props
bind gpk_ports gpk_ports_props chk (.*);

// ==== test/gpk_pins_model.sv ====
// external circuitry on one 8-bit port
`timescale 1ns/100ps
module gpk_pins_model
(
   input wire clk_sys,
   input wire [7:0] out,
   input wire [7:0] oe_n,
   input wire [7:0] pull,
   input wire [7:0] ext,
   input wire [7:0] ext_en,
   output wire [7:0] pin
);
reg [7:0] last = 8'h00;
// undriven, unpulled lines flip each cycle so no stale value passes
assign pin = (~oe_n & out) | (oe_n & ext_en & ext)
   | (oe_n & ~ext_en & (pull | ~last));
always @(posedge clk_sys)
   last <= pin;
endmodule // gpk_pins_model

// ==== test/testbench.sv ====
// self-checking bench for the port block
`timescale 1ns/100ps
module testbench;
reg clk_sys = 0, srst = 1, wr_stb = 0, rd_stb = 0, sc = 1, gp = 1, ax = 0;
reg [7:0] addr = 0, wdata = 0, xv = 8'h3c, xd = 8'hff, hae = 0;
reg ec = 1, xc = 1;
integer failures = 0, cmp_count = 0;
wire [7:0] rdata, ho, hoe, hpu, hi, jo, joe, ji, ko, koe, ki;
wire [2:0] jt, kt;
wire [1:0] ad;
wire bp, fp, gpo, pc, iv, ep, ls, sr, ld, xp;
always #4 clk_sys = ~clk_sys;
gpk_ports dut (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .single_chip_mode(sc),
   .read_vis_reset_val(1'b1), .global_pullup_en(gp), .e_clock(ec),
   .aux_clock_out_en(ax), .aux_clock(xc), .h_alt_en(hae),
   .h_alt_out(8'h5a), .j_alt_en(hae), .j_alt_out(8'h00), .k_alt_en(hae),
   .k_alt_out(xv), .port_h_in(hi), .port_h_out(ho), .port_h_oe_n(hoe),
   .port_h_pullup(hpu), .port_j_in(ji), .port_j_out(jo), .port_j_oe_n(joe),
   .port_k_in(ki), .port_k_out(ko), .port_k_oe_n(koe), .j_timer_in(jt),
   .k_timer_in(kt), .b_pullup_on(bp), .f_pullup_on(fp), .g_pullup_on(gpo),
   .port_c_open_drain(pc), .int_read_vis(iv), .e_pin_out(ep),
   .spi_lsb_first(ls), .spi_rate_sel_hi(sr), .load_instr_drive_en(ld),
   .aux_clk_div_sel(ad), .aux_clock_pin(xp));
gpk_pins_model mh (.clk_sys(clk_sys), .out(ho), .oe_n(hoe), .pull(hpu),
   .ext(xv), .ext_en(xd), .pin(hi));
gpk_pins_model mj (.clk_sys(clk_sys), .out(jo), .oe_n(joe), .pull(8'h00),
   .ext(xv), .ext_en(xd), .pin(ji));
gpk_pins_model mk (.clk_sys(clk_sys), .out(ko), .oe_n(koe), .pull(8'h00),
   .ext(xv), .ext_en(xd), .pin(ki));
// ---
// bus cycles and comparison
// ---
task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
begin
   cmp_count = cmp_count + 1;
   if (g !== e)
   begin
      failures = failures + 1;
      $display("unexpected %0s exp %h got %h", nm, e, g);
   end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
   addr <= a;
   wdata <= d;
   wr_stb <= 1'b1;
   rd_stb <= 1'b0;
   @(posedge clk_sys);
end
endtask
task rd(input [7:0] a, input [7:0] e, input [8*8:1] nm);
begin
   addr <= a;
   rd_stb <= 1'b1;
   wr_stb <= 1'b0;
   @(posedge clk_sys);
   rd_stb <= 1'b0;
   #1 chk(nm, e, rdata);
   @(posedge clk_sys);
end
endtask
task idle(input integer n);
begin
   wr_stb <= 1'b0;
   rd_stb <= 1'b0;
   repeat (n) @(posedge clk_sys);
   #1;
end
endtask
// ---
// scenarios
// ---
task t_reset;
begin
   idle(2);
   rd(8'h7d, 8'h00, "h dir");
   rd(8'h8f, 8'h00, "j dir");
   rd(8'h2c, 8'h0f, "pullreg");
   rd(8'h38, 8'h10, "sys_options_two_reg");
   rd(8'h40, 8'h00, "unmapped");
   chk("pulls", 8'hff, {bp, fp, gpo, 5'h1f} | (hpu ^ 8'hff));
   chk("timers", 8'h09, {2'h0, jt, kt});
   $display("reset test done");
end
endtask
task t_ports;
begin
   wr(8'h7c, 8'ha5);
   wr(8'h7d, 8'hf0);
   wr(8'h9f, 8'h0f);
   idle(2);
   chk("h oe_n", 8'h0f, hoe);
   chk("h pins", 8'hac, hi);
   rd(8'h7c, 8'hac, "h data");
   hae <= 8'hf0;
   wr(8'h7c, 8'h00);
   idle(2);
   chk("h alt", 8'h50, ho & 8'hf0);
   rd(8'h7c, 8'h0c, "h data2");
   $display("port test done");
end
endtask
task t_pull;
begin
   wr(8'h2c, 8'hf4);
   idle(2);
   rd(8'h2c, 8'h04, "pullreg");
   chk("g only", 8'h04, {5'h0, gpo, fp, bp});
   wr(8'h2c, 8'h0f);
   gp <= 1'b0;
   idle(2);
   chk("glob off", 8'h00, {hpu[7:1], gpo});
   gp <= 1'b1;
   sc <= 1'b0;
   idle(2);
   chk("expanded", 8'h04, {5'h0, gpo, fp, bp});
   sc <= 1'b1;
   $display("pull-up test done");
end
endtask
task t_sys_options_two_reg;
begin
   wr(8'h38, 8'hff);
   ax <= 1'b1;
   idle(2);
   rd(8'h38, 8'hdf, "sys_options_two_reg");
   chk("opt outs", 8'hcf, {ld, pc, 1'b0, iv, ls, sr, ad});
   chk("e pin", 8'h02, {6'h0, xp, ep});
   sc <= 1'b0;
   idle(2);
   chk("vis", 8'h03, {6'h0, iv, ep});
   sc <= 1'b1;
   wr(8'h38, 8'h00);
   idle(2);
   chk("opt zero", 8'h00, {ld, pc, 1'b0, iv, ls, sr, ad});
   $display("options test done");
end
endtask
task final_report;
begin
   $display("comparisons %0d mismatches %0d", cmp_count, failures);
   if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
end
endtask
initial
begin
   #20000;
   failures = failures + 1;
   final_report;
end
initial
begin
   repeat (8) @(posedge clk_sys);
   srst <= 1'b0;
   t_reset;
   t_ports;
   t_pull;
   t_sys_options_two_reg;
   final_report;
end
endmodule // testbench
